/* core/poc_top.sv */
`timescale 1ns/1ns
`include "poc_defs.svh"
// Operation
// RQ1: A stage starts when any phase current exceeds its start threshold.
// RQ2: Starting drives the start output and display indication together.
// RQ3: Started longer than operate time asserts main trip and red indicator.
// RQ4: Red indicator holds after dropout until the reset button is pressed.
// RQ5: Output configuration can add an auxiliary trip output.
// RQ6: Blocking input inhibits operation of the stages it is routed to.
// RQ7: Three switch bits pick definite time or one of six inverse curves; all six codes select the same fixed inv_time delay.
// RQ8: Low-set definite delay spans 0.05 s to 300 s.
// RQ9: Inverse mode caps the low-set start threshold at 2.5 rated current.
// RQ10: High-set starting blocks inverse-time operation of the low-set stage.
// RQ11: High-set delay spans 0.04 s to 300 s.
// RQ12: Latch switch keeps main trip asserted after the stage drops out.
// RQ13: Latched trip clears by reset plus program, or by release command.
// RQ14: A function switch enables high-set threshold doubling at energising.
// RQ15: Doubling starts on a rise from below 0.12 to above 1.5 within 60 ms.
// RQ16: Doubling ends once currents fall below 1.25 times low-set threshold.
// RQ17: High-set start threshold spans 0.5 to 40 times rated current.
// RQ18: A function switch disables the high-set stage, treating it infinite.
// RQ19: A timer restarts from zero when its stage drops out early.
// RQ20: Timers run on a fixed 10 ms time base from the system clock.
module poc_top
    import poc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `POC_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] phase_a,
    input wire logic [15:0] phase_b,
    input wire logic [15:0] phase_c,
    input wire logic block_in,
    input wire logic reset_button,
    input wire logic program_button,
    output logic start_out_a,
    output logic start_or_aux_trip_out,
    output logic main_trip_out,
    output logic trip_indicator,
    output logic start_ind_low,
    output logic start_ind_high,
    output logic high_dashes
);

    // ======================================================================
    // Helper functions.
    // ======================================================================
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [23:0] scale(input logic [15:0] v,
                                          input logic [7:0] k);
        return 24'(v) * 24'(k);
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic any_above(input logic [16:0] th);
        return ({1'b0, phase_a} > th) || ({1'b0, phase_b} > th) ||
               ({1'b0, phase_c} > th);
    endfunction

    // ======================================================================
    // Pin synchronisers.
    // ======================================================================
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {program_button, reset_button, block_in};
            pin_sync <= pin_meta;
        end
    end

    wire block_s = pin_sync[0];
    wire reset_s = pin_sync[1];
    wire program_s = pin_sync[2];

    // ======================================================================
    // Register file on the Avalon-MM slave.
    // ======================================================================
    logic [7:0] function_switch_group_one;
    logic [7:0] function_switch_group_two;
    logic [7:0] blocking_switch_group;
    logic [7:0] out_cfg;
    logic [15:0] low_start;
    logic [15:0] high_start;
    logic [15:0] low_time;
    logic [15:0] high_time;
    logic [15:0] inv_time;
    logic latch_release_command;
    logic dbl_active;
    logic low_exp;
    logic high_exp;

    wire reg_wr = avs_write && !avs_waitrequest;
    wire [5:0] ofs = {avs_address[5:2], 2'b00};
    wire sel_function_switch_group_one = (ofs == `POC_OFS_FUNCTION_SWITCH_GROUP_ONE);
    wire sel_function_switch_group_two = (ofs == `POC_OFS_FUNCTION_SWITCH_GROUP_TWO);
    wire sel_sgb = (ofs == `POC_OFS_SGB);
    wire sel_out = (ofs == `POC_OFS_OUTCFG);
    wire sel_ls = (ofs == `POC_OFS_LOW_START);
    wire sel_hs = (ofs == `POC_OFS_HIGH_START);
    wire sel_lt = (ofs == `POC_OFS_LOW_TIME);
    wire sel_ht = (ofs == `POC_OFS_HIGH_TIME);
    wire sel_it = (ofs == `POC_OFS_INV_TIME);
    wire sel_cmd = (ofs == `POC_OFS_CMD);
    wire sel_st = (ofs == `POC_OFS_STATUS);

    wire [31:0] status_word = {24'h000000, block_s, dbl_active,
        trip_indicator, main_trip_out, high_exp, low_exp,
        start_ind_high, start_ind_low};

    wire [31:0] rd_value =
        sel_function_switch_group_one ? {24'h000000, function_switch_group_one} :
        sel_function_switch_group_two ? {24'h000000, function_switch_group_two} :
        sel_sgb ? {24'h000000, blocking_switch_group} :
        sel_out ? {24'h000000, out_cfg} :
        sel_ls ? {16'h0000, low_start} :
        sel_hs ? {16'h0000, high_start} :
        sel_lt ? {16'h0000, low_time} :
        sel_ht ? {16'h0000, high_time} :
        sel_it ? {16'h0000, inv_time} :
        sel_st ? status_word : 32'h00000000;

    wire [31:0] wr_value = be_merge(rd_value, avs_writedata, avs_byteenable);
    wire next_waitrequest = !(avs_waitrequest && (avs_read || avs_write));

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= next_waitrequest;
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_value;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            function_switch_group_one <= `POC_RST_SWITCH;
            function_switch_group_two <= `POC_RST_SWITCH;
            blocking_switch_group <= `POC_RST_SWITCH;
            out_cfg <= `POC_RST_SWITCH;
            low_start <= `POC_RST_LOW_START;
            high_start <= `POC_RST_HIGH_START;
            low_time <= `POC_RST_LOW_TIME;
            high_time <= `POC_RST_HIGH_TIME;
            inv_time <= `POC_RST_INV_TIME;
        end else if (reg_wr) begin
            if (sel_function_switch_group_one) function_switch_group_one <= wr_value[7:0];
            if (sel_function_switch_group_two) function_switch_group_two <= wr_value[7:0];
            if (sel_sgb) blocking_switch_group <= wr_value[7:0];
            if (sel_out) out_cfg <= wr_value[7:0];
            if (sel_ls) low_start <= wr_value[15:0];
            if (sel_hs) high_start <= wr_value[15:0];
            if (sel_lt) low_time <= wr_value[15:0];
            if (sel_ht) high_time <= wr_value[15:0];
            if (sel_it) inv_time <= wr_value[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_release_command <= 1'b0;
        end else begin
            latch_release_command <= reg_wr && sel_cmd && avs_byteenable[0] &&
                avs_writedata[`POC_CMD_RELEASE];
        end
    end

    // ======================================================================
    // Time base.
    // ======================================================================
    logic [19:0] tick_cnt;
    logic tick;
    wire tick_wrap = (tick_cnt == 20'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tick_cnt <= 20'h00000;
            tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? 20'h00000 : tick_cnt + 20'h00001; // RQ20
            tick <= tick_wrap; // RQ20
        end
    end

    // ======================================================================
    // Thresholds and starting.
    // ======================================================================
    wire [2:0] curve_sel =
        function_switch_group_one[`POC_FUNCTION_SWITCH_GROUP_ONE_CURVE_LSB +: 3];
    wire inverse_time_mode = (curve_sel != POC_DEFINITE) && // RQ7
                             (curve_sel != POC_CURVE_RSV);
    wire [15:0] low_eff = (inverse_time_mode && low_start > `POC_INV_CAP) ?
                          `POC_INV_CAP : low_start; // RQ9
    wire [15:0] high_eff = clamp16(high_start, `POC_HIGH_MIN,
                                   `POC_HIGH_MAX); // RQ17
    wire high_off = function_switch_group_two[`POC_FUNCTION_SWITCH_GROUP_TWO_HIGH_OFF];
    wire [16:0] high_th = dbl_active ? {high_eff, 1'b0} : {1'b0, high_eff};
    wire low_started = any_above({1'b0, low_eff}); // RQ1
    wire high_started = !high_off && any_above(high_th); // RQ1 RQ18

    // ======================================================================
    // Threshold doubling at energisation.
    // ======================================================================
    wire [15:0] peak = (phase_a > phase_b) ?
        ((phase_a > phase_c) ? phase_a : phase_c) :
        ((phase_b > phase_c) ? phase_b : phase_c);
    wire [23:0] peak_pct = scale(peak, `POC_PERCENT);
    wire below_012 = peak_pct < scale(low_eff, `POC_DBL_LOW_PCT);
    wire above_150 = peak_pct > scale(low_eff, `POC_DBL_HIGH_PCT);
    wire below_125 = peak_pct < scale(low_eff, `POC_DBL_END_PCT);
    wire dbl_enable = function_switch_group_one[`POC_FUNCTION_SWITCH_GROUP_ONE_DOUBLE];

    logic seen_low;
    logic [3:0] since_low;
    wire inrush_recent = seen_low && (since_low < 4'(`POC_INRUSH_TICKS));

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seen_low <= 1'b0;
            since_low <= 4'h0;
            dbl_active <= 1'b0;
        end else begin
            if (below_012) begin
                seen_low <= 1'b1;
                since_low <= 4'h0;
            end else if (tick && inrush_recent) begin
                since_low <= since_low + 4'h1; // RQ15
            end
            if (!dbl_enable) begin
                dbl_active <= 1'b0; // RQ14
            end else if (dbl_active && below_125) begin
                dbl_active <= 1'b0; // RQ16
            end else if (inrush_recent && above_150) begin
                dbl_active <= 1'b1; // RQ15
            end
        end
    end

    // ======================================================================
    // Operate timers.
    // ======================================================================
    wire block_low = block_s && blocking_switch_group[`POC_SGB_BLOCK_LOW];
    wire block_high = block_s && blocking_switch_group[`POC_SGB_BLOCK_HIGH];
    wire low_run = low_started && !block_low && // RQ6
                   !(inverse_time_mode && high_started); // RQ10
    wire high_run = high_started && !block_high; // RQ6
    wire [15:0] low_delay = inverse_time_mode ? inv_time :
        clamp16(low_time, 16'(`POC_LOW_MIN_TICKS),
                16'(`POC_MAX_TICKS)); // RQ8
    wire [15:0] high_delay = clamp16(high_time, 16'(`POC_HIGH_MIN_TICKS),
                                     16'(`POC_MAX_TICKS)); // RQ11

    poc_stage_timer u_low_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(tick),
        .run(low_run),
        .delay(low_delay),
        .expired(low_exp)
    );

    poc_stage_timer u_high_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(tick),
        .run(high_run),
        .delay(high_delay),
        .expired(high_exp)
    );

    // ======================================================================
    // Trip, latching and indication.
    // ======================================================================
    wire trip_now = low_exp || high_exp;
    wire latch_en = blocking_switch_group[`POC_SGB_LATCH];
    wire aux_en = out_cfg[`POC_OUTCFG_AUX];
    wire latch_clear = (reset_s && program_s) || latch_release_command;
    wire next_main_trip = trip_now || // RQ3
        (latch_en && main_trip_out && !latch_clear); // RQ12 RQ13
    wire next_indicator = trip_now || (trip_indicator && !reset_s); // RQ4

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_out_a <= 1'b0;
            start_or_aux_trip_out <= 1'b0;
            main_trip_out <= 1'b0;
            trip_indicator <= 1'b0;
            start_ind_low <= 1'b0;
            start_ind_high <= 1'b0;
            high_dashes <= 1'b0;
        end else begin
            start_out_a <= low_started; // RQ2
            start_ind_low <= low_started; // RQ2
            start_ind_high <= high_started; // RQ2
            start_or_aux_trip_out <= high_started ||
                (aux_en && trip_now); // RQ5
            main_trip_out <= next_main_trip;
            trip_indicator <= next_indicator;
            high_dashes <= high_off; // RQ18
        end
    end

    // ======================================================================
    // Checks.
    // ======================================================================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence inrush_rise_s;
        dbl_enable && inrush_recent && above_150 && !dbl_active;
    endsequence

    sequence trip_seen_s;
        trip_now ##1 (main_trip_out && trip_indicator);
    endsequence

    start_together_a: assert property ( // RQ2
        low_started |=> start_out_a && start_ind_low)
        else $error("start output and indication not together");

    trip_raise_a: assert property (trip_now |-> trip_seen_s) // RQ3
        else $error("trip did not raise output and indicator");

    indicator_hold_a: assert property ( // RQ4
        trip_indicator && !reset_s |=> trip_indicator)
        else $error("indicator dropped without reset button");

    aux_trip_a: assert property ( // RQ5
        aux_en && trip_now |=> start_or_aux_trip_out)
        else $error("auxiliary trip missing");

    block_low_a: assert property (block_low |=> !low_exp) // RQ6
        else $error("blocked low stage still running");

    inv_cap_a: assert property ( // RQ9
        inverse_time_mode && any_above({1'b0, `POC_INV_CAP}) |-> low_started)
        else $error("inverse threshold above cap");

    inv_block_a: assert property ( // RQ10
        inverse_time_mode && high_started |=> !$rose(low_exp))
        else $error("inverse low stage ran while high-set started");

    latch_hold_a: assert property ( // RQ12
        main_trip_out && latch_en && !latch_clear |=> main_trip_out)
        else $error("latched trip dropped");

    latch_clear_a: assert property ( // RQ13
        main_trip_out && latch_clear && !trip_now |=> !main_trip_out)
        else $error("latched trip not cleared");

    dbl_start_a: assert property (inrush_rise_s |=> dbl_active) // RQ15
        else $error("doubling did not start on inrush");

    dbl_end_a: assert property ( // RQ16
        dbl_active && below_125 |=> !dbl_active)
        else $error("doubling did not end");

    high_off_a: assert property (high_off |=> !start_ind_high) // RQ18
        else $error("disabled high-set stage started");

    tick_space_a: assert property (tick |=> !tick) // RQ20
        else $error("time base ticks back to back");

endmodule

/* core/poc_defs.svh */
`ifndef POC_DEFS_SVH
`define POC_DEFS_SVH

// ==========================================================================
// Register byte offsets.
// ==========================================================================
`define POC_OFS_FUNCTION_SWITCH_GROUP_ONE 6'h00
`define POC_OFS_FUNCTION_SWITCH_GROUP_TWO 6'h04
`define POC_OFS_SGB 6'h08
`define POC_OFS_OUTCFG 6'h0C
`define POC_OFS_LOW_START 6'h10
`define POC_OFS_HIGH_START 6'h14
`define POC_OFS_LOW_TIME 6'h18
`define POC_OFS_HIGH_TIME 6'h1C
`define POC_OFS_INV_TIME 6'h20
`define POC_OFS_CMD 6'h24
`define POC_OFS_STATUS 6'h28

// ==========================================================================
// Field positions.
// ==========================================================================
`define POC_FUNCTION_SWITCH_GROUP_ONE_CURVE_LSB 0
`define POC_FUNCTION_SWITCH_GROUP_ONE_DOUBLE 4
`define POC_FUNCTION_SWITCH_GROUP_TWO_HIGH_OFF 4
`define POC_SGB_BLOCK_LOW 0
`define POC_SGB_BLOCK_HIGH 1
`define POC_SGB_LATCH 5
`define POC_OUTCFG_AUX 0
`define POC_CMD_RELEASE 0

// ==========================================================================
// Reset values; currents count in hundredths of rated current.
// ==========================================================================
`define POC_RST_SWITCH 8'h00
`define POC_RST_LOW_START 16'h0064
`define POC_RST_HIGH_START 16'h0190
`define POC_RST_LOW_TIME 16'h0005
`define POC_RST_HIGH_TIME 16'h0004
`define POC_RST_INV_TIME 16'h0064

// ==========================================================================
// Current scaling.
// ==========================================================================
`define POC_PERCENT 8'h64
`define POC_INV_CAP 16'h00FA
`define POC_HIGH_MIN 16'h0032
`define POC_HIGH_MAX 16'h0FA0
`define POC_DBL_LOW_PCT 8'h0C
`define POC_DBL_HIGH_PCT 8'h96
`define POC_DBL_END_PCT 8'h7D

// ==========================================================================
// Timing.
// ==========================================================================
`define POC_CLK_PERIOD_NS 10
`define POC_TICK_MS 10
`define POC_TICK_CYCLES ((`POC_TICK_MS * 1000000) / `POC_CLK_PERIOD_NS)
`define POC_INRUSH_MS 60
`define POC_INRUSH_TICKS (`POC_INRUSH_MS / `POC_TICK_MS)
`define POC_LOW_TIME_MIN_MS 50
`define POC_HIGH_TIME_MIN_MS 40
`define POC_TIME_MAX_S 300
`define POC_LOW_MIN_TICKS \
    ((`POC_LOW_TIME_MIN_MS + `POC_TICK_MS - 1) / `POC_TICK_MS)
`define POC_HIGH_MIN_TICKS \
    ((`POC_HIGH_TIME_MIN_MS + `POC_TICK_MS - 1) / `POC_TICK_MS)
`define POC_MAX_TICKS ((`POC_TIME_MAX_S * 1000) / `POC_TICK_MS)

`endif

/* core/poc_pkg.sv */
package poc_pkg;

    typedef enum logic [2:0] {
        POC_DEFINITE = 3'b000,
        POC_CURVE_1 = 3'b001,
        POC_CURVE_2 = 3'b010,
        POC_CURVE_3 = 3'b011,
        POC_CURVE_4 = 3'b100,
        POC_CURVE_5 = 3'b101,
        POC_CURVE_6 = 3'b110,
        POC_CURVE_RSV = 3'b111
    } poc_curve_t;

    typedef enum logic [1:0] {
        POC_IDLE = 2'b00,
        POC_TIMING = 2'b01,
        POC_OPERATED = 2'b10
    } poc_tmr_state_t;

endpackage

/* core/poc_stage_timer.sv */
`timescale 1ns/1ns
module poc_stage_timer
    import poc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic run,
    input wire logic [15:0] delay,
    output logic expired
);

    poc_tmr_state_t state;
    logic [15:0] cnt;
    wire reached = (cnt >= delay);

    assign expired = (state == POC_OPERATED);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= POC_IDLE;
            cnt <= 16'h0000;
        end else if (!run) begin
            state <= POC_IDLE; // RQ19
            cnt <= 16'h0000; // RQ19
        end else begin
            case (state)
                POC_IDLE: begin
                    state <= POC_TIMING;
                end
                POC_TIMING: begin
                    if (reached) begin
                        state <= POC_OPERATED;
                    end else if (tick) begin
                        cnt <= cnt + 16'h0001; // RQ20
                    end
                end
                POC_OPERATED: begin
                    state <= POC_OPERATED;
                end
                default: begin
                    state <= POC_IDLE;
                end
            endcase
        end
    end

    restart_zero_a: assert property ( // RQ19
        @(posedge sys_clk) disable iff (srst)
        !run |=> (cnt == 16'h0000) && !expired)
        else $error("timer did not restart after dropout");

    expire_time_a: assert property ( // RQ3
        @(posedge sys_clk) disable iff (srst)
        (state == POC_TIMING) && run && reached |=> expired)
        else $error("timer did not expire at its delay");

endmodule

/* testbench/poc_partner.sv */
`timescale 1ns/1ns
// ==========================================
// Current source on one chosen phase, and a relay counter.
// ==========================================
module poc_partner (
    input wire logic sys_clk,
    input wire logic [15:0] level,
    input wire logic [1:0] sel,
    output logic [15:0] phase_a,
    output logic [15:0] phase_b,
    output logic [15:0] phase_c,
    input wire logic main_trip_out,
    output int trip_count
);
    logic last;
    initial trip_count = 0;
    initial last = 1'b0;
    always @(posedge sys_clk) begin
        phase_a <= (sel == 2'h0) ? level : 16'h0000;
        phase_b <= (sel == 2'h1) ? level : 16'h0000;
        phase_c <= (sel == 2'h2) ? level : 16'h0000;
        last <= main_trip_out;
        if (main_trip_out === 1'b1 && last !== 1'b1) begin
            trip_count <= trip_count + 1;
        end
    end
endmodule

/* testbench/poc_top_tb.sv */
`timescale 1ns/1ns
`include "poc_defs.svh"
module poc_top_tb;
    import poc_pkg::*;
    logic sys_clk = 0, srst = 1, avs_read = 0, avs_write = 0, block_in = 0;
    logic reset_button = 0, program_button = 0, sa, sx, mt, ti, sl, sh, hd;
    logic avs_waitrequest;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, seed = 32'h13;
    logic [15:0] level = 16'h0, pa, pb, pc;
    logic [1:0] sel = 2'h0;
    int n_fail = 0, cmp_count = 0, trips, n, i;
    always #5 sys_clk = ~sys_clk;
    poc_partner u_part (.sys_clk(sys_clk), .level(level), .sel(sel),
        .phase_a(pa), .phase_b(pb), .phase_c(pc), .main_trip_out(mt),
        .trip_count(trips));
    poc_top #(.TICK_CYCLES(10)) u_dut (.sys_clk(sys_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .phase_a(pa), .phase_b(pb),
        .phase_c(pc), .block_in(block_in), .reset_button(reset_button),
        .program_button(program_button), .start_out_a(sa),
        .start_or_aux_trip_out(sx), .main_trip_out(mt),
        .trip_indicator(ti), .start_ind_low(sl), .start_ind_high(sh),
        .high_dashes(hd));
    // ==========================================
    // Helpers.
    // ==========================================
    function automatic logic above(input logic [15:0] l, input int t);
        return l > t;
    endfunction
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k == 20) begin
            n_fail++;
            $display("FAIL bus_wait expected 0 seen %b", avs_waitrequest);
            close_out();
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic wait_trip(output int c);
        for (c = 0; c < 300 && mt !== 1'b1; c++) begin
            @(posedge sys_clk);
        end
        if (c == 300) begin
            n_fail++;
            $display("FAIL trip_wait expected 1 seen %b", mt);
            close_out();
        end
    endtask
    // ==========================================
    // Main sequence.
    // ==========================================
    initial begin
        idle(16);
        srst <= 1'b0;
        bus(1'b0, `POC_OFS_LOW_START, 32'h0);
        chk("low_start", 32'h64, q);
        bus(1'b0, `POC_OFS_HIGH_START, 32'h0);
        chk("high_start", 32'h190, q);
        bus(1'b0, 6'h3C, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, `POC_OFS_SGB, 32'h3);
        block_in <= 1'b1;
        for (i = 0; i < 10; i++) begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            level <= (i == 0) ? 16'h0065 : {7'h0, seed[8:0]};
            sel <= (seed[10:9] == 2'h3) ? 2'h0 : seed[10:9];
            idle(4);
            chk("start_low", above(level, 100), sa);
            chk("ind_low", above(level, 100), sl);
            chk("ind_high", above(level, 400), sh);
            chk("start_high", above(level, 400), sx);
        end
        level <= 16'h00C8;
        idle(100);
        chk("blocked", 0, trips);
        block_in <= 1'b0;
        wait_trip(n);
        chk("delay_min", 1, n >= 40);
        chk("indicator", 1'b1, ti);
        level <= 16'h0;
        idle(6);
        chk("trip_drop", 1'b0, mt);
        chk("ind_hold", 1'b1, ti);
        reset_button <= 1'b1;
        idle(6);
        reset_button <= 1'b0;
        chk("ind_clear", 1'b0, ti);
        bus(1'b1, `POC_OFS_SGB, 32'h20);
        bus(1'b1, `POC_OFS_OUTCFG, 32'h1);
        level <= 16'h00C8;
        wait_trip(n);
        idle(2);
        chk("aux_trip", 1'b1, sx);
        level <= 16'h0;
        idle(8);
        chk("latched", 1'b1, mt);
        bus(1'b1, `POC_OFS_CMD, 32'h1);
        idle(4);
        chk("released", 1'b0, mt);
        bus(1'b1, `POC_OFS_FUNCTION_SWITCH_GROUP_TWO, 32'h10);
        level <= 16'h01F4;
        idle(4);
        chk("high_off", 1'b0, sh);
        chk("dashes", 1'b1, hd);
        level <= 16'h0;
        block_in <= 1'b1;
        bus(1'b1, `POC_OFS_SGB, 32'h22);
        bus(1'b1, `POC_OFS_FUNCTION_SWITCH_GROUP_ONE, 32'h1);
        bus(1'b1, `POC_OFS_INV_TIME, 32'h5);
        bus(1'b1, `POC_OFS_LOW_START, 32'h1F4);
        bus(1'b1, `POC_OFS_FUNCTION_SWITCH_GROUP_TWO, 32'h0);
        level <= 16'h01F4;
        idle(100);
        bus(1'b0, `POC_OFS_STATUS, 32'h0);
        chk("inv_blocked", 0, q[2]);
        chk("st_high", 1, q[1]);
        level <= 16'h012C;
        wait_trip(n);
        chk("inv_start", 1, sa);
        chk("inv_delay", 1, n >= 40);
        level <= 16'h0;
        reset_button <= 1'b1;
        program_button <= 1'b1;
        idle(6);
        chk("btn_clear", 0, mt);
        reset_button <= 1'b0;
        program_button <= 1'b0;
        bus(1'b1, `POC_OFS_FUNCTION_SWITCH_GROUP_ONE, 32'h10);
        bus(1'b1, `POC_OFS_LOW_START, 32'h64);
        idle(4);
        level <= 16'h01F4;
        idle(4);
        chk("dbl_on", 0, sh);
        idle(80);
        level <= 16'h0064;
        idle(4);
        level <= 16'h01F4;
        idle(4);
        chk("dbl_off", 1, sh);
        close_out();
    end
endmodule
